//--- pprf_pkg.sv
// Purpose: Shared constants for the process regulator with fault handling.
// Assumes: APB slave with 32-bit data, one word per register, 50 MHz pclk.
// Notes: Byte offsets, reset values and timing counts live here.
package pprf_pkg;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned TICK_PERIOD_NS = 1000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);

    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_FB_SEL = 8'h04;
    localparam logic [7:0] OFS_SLEEP_SEL = 8'h08;
    localparam logic [7:0] OFS_SETPOINT = 8'h0C;
    localparam logic [7:0] OFS_KP = 8'h10;
    localparam logic [7:0] OFS_TI = 8'h14;
    localparam logic [7:0] OFS_KD = 8'h18;
    localparam logic [7:0] OFS_SLEEP_LVL = 8'h1C;
    localparam logic [7:0] OFS_SLEEP_DLY = 8'h20;
    localparam logic [7:0] OFS_WAKE_LVL = 8'h24;
    localparam logic [7:0] OFS_WAKE_DLY = 8'h28;
    localparam logic [7:0] OFS_MAIN_SRC = 8'h2C;
    localparam logic [7:0] OFS_PROT = 8'h30;
    localparam logic [7:0] OFS_RATED = 8'h34;
    localparam logic [7:0] OFS_DI_FUNC = 8'h38;
    localparam logic [7:0] OFS_DISP_RANGE = 8'h3C;
    localparam logic [7:0] OFS_DISP_UNIT = 8'h40;
    localparam logic [7:0] OFS_DISP_VAL = 8'h44;
    localparam logic [7:0] OFS_STATUS = 8'h48;
    localparam logic [7:0] OFS_FAULT_CLR = 8'h4C;
    localparam logic [7:0] OFS_PID_OUT = 8'h50;
    localparam logic [7:0] OFS_HISTORY = 8'h54;

    localparam logic [3:0] MODE_RESET = 4'h0;
    localparam logic [7:0] FB_SEL_RESET = 8'h01;
    localparam logic [15:0] KP_RESET = 16'h0200;
    localparam logic [15:0] TI_RESET = 16'h0005;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    localparam logic [7:0] FB_SEL_VOLT = 8'h01;
    localparam logic [7:0] FB_SEL_CURR = 8'h02;
    localparam logic [15:0] FB_LIVE_ZERO = 16'h3333;
    localparam logic [7:0] SLEEP_OFF = 8'h00;
    localparam logic [7:0] SLEEP_LEVEL = 8'h01;
    localparam logic [7:0] SLEEP_INPUT = 8'h02;
    localparam logic [7:0] MAIN_SRC_PID = 8'h05;
    localparam logic [7:0] DI_FAULT_RESET = 8'h11;

    localparam logic [7:0] CODE_NONE = 8'h00;
    localparam logic [7:0] CODE_OVERCURRENT = 8'h01;
    localparam logic [7:0] CODE_SHORT = 8'h02;
    localparam logic [7:0] CODE_GROUND = 8'h03;

    localparam logic signed [23:0] INTEG_MAX = 24'sh7FFFFF;
    localparam logic signed [23:0] INTEG_MIN = -24'sh7FFFFF;
endpackage

//--- pprf_plant.sv
// Purpose: Behavioural transducer and output stage that feed the regulator.
// Assumes: The bench sets the process level, load, leakage and short demand.
// Notes: Every output is registered once, as a real sensor lags its input.
`timescale 1ns/1ps
module pprf_plant
    import pprf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] fb_set,
    input wire logic [15:0] load,
    input wire logic [15:0] leak,
    input wire logic short_cmd,
    output logic [15:0] feedback_volt,
    output logic [15:0] feedback_curr,
    output logic [15:0] out_current,
    output logic [15:0] ground_current,
    output logic short_detect
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {feedback_volt, feedback_curr, out_current, ground_current, short_detect} <= '0;
        end else begin
            feedback_volt <= fb_set;
            feedback_curr <= FB_LIVE_ZERO + fb_set;
            out_current <= load;
            ground_current <= leak;
            short_detect <= short_cmd;
        end
    end
endmodule

//--- pprf_top.sv
// Purpose: Process regulator with sleep supervisor and latched fault handling.
// Assumes: Inputs are synchronous to pclk; APB master holds requests until pready.
// Notes: Gains are Q8.8; delays and integral time count 1 us control updates.
//
// What this block does
// - Error equals setpoint minus feedback each update
// - Proportional gain scales the error
// - Longer integral time slows integral accumulation
// - Mode bit 0 turns regulator on
// - Mode bit 1 selects negative characteristic
// - Mode bit 2 picks derivative input source
// - Mode bit 3 adds target to output
// - Mode 0001b raises speed when feedback low
// - Mode 0011b lowers speed when feedback low
// - Regulator drives reference only when source 5
// - Feedback select 2 current, 1 voltage
// - Sleep select: off, level-based, digital input
// - Sleep after output below level for delay
// - Wake after output above level for delay
// - Fault shows code, contact, coast stop (ramp stop instead for ground leak when ramp select is set)
// - Warning shows code, contact stays off
// - Fault clears by input 17, keypad, power
// - Each newly latched fault code shifted into a four-entry history store
// - Overcurrent trips above 200% rated
// - Ground leak trips above 50% rated
// - Short trip when protection setting enabled
// - Setpoint scaled for engineering unit display
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module pprf_top
    import pprf_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] feedback_volt,
    input wire logic [15:0] feedback_curr,
    input wire logic [15:0] other_ref,
    input wire logic [15:0] out_current,
    input wire logic [15:0] ground_current,
    input wire logic short_detect,
    input wire logic sleep_input,
    input wire logic digital_in,
    input wire logic keypad_reset,
    input wire logic [7:0] warning_in,
    output logic [15:0] freq_ref,
    output logic output_on,
    output logic fault_contact,
    output logic [7:0] fault_code,
    output logic [7:0] warning_code,
    output logic coast_stop,
    output logic ramp_stop
);
    import pprf_pkg::*;

    typedef struct packed {
        logic [3:0] mode;
        logic [7:0] fb_sel;
        logic [7:0] sleep_sel;
        logic [7:0] main_src;
        logic ground_en;
        logic ramp_sel;
        logic [7:0] di_func;
        logic [15:0] setpoint;
        logic [15:0] kp;
        logic [15:0] ti;
        logic [15:0] kd;
        logic [15:0] sleep_lvl;
        logic [15:0] sleep_dly;
        logic [15:0] wake_lvl;
        logic [15:0] wake_dly;
        logic [15:0] rated;
        logic [15:0] disp_range;
        logic [7:0] disp_unit;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [5:0] tick_cnt;
        logic [15:0] ti_cnt;
        logic signed [23:0] integ;
        logic signed [16:0] d_prev;
        logic [15:0] pid_out;
        logic [15:0] freq_ref;
        logic asleep;
        logic [15:0] delay_cnt;
        logic output_on;
        logic [7:0] fault_code;
        logic fault_contact;
        logic coast_stop;
        logic ramp_stop;
        logic [7:0] warn_code;
        logic [31:0] history;
    } pprf_state_s;

    pprf_state_s state_reg;
    pprf_state_s state_next;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [15:0] pprf_clamp16(input logic signed [35:0] v);
        if (v < 36'sd0) begin
            return 16'h0000;
        end else if (v > 36'sd65535) begin
            return 16'hFFFF;
        end
        return v[15:0];
    endfunction

    function automatic logic signed [35:0] pprf_mul_q8(input logic signed [17:0] a, input logic [15:0] g);
        logic signed [35:0] prod;
        prod = 36'(a) * 36'(signed'({1'b0, g}));
        return prod >>> 8;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Combinational datapath.

    logic tick;
    logic bus_setup;
    logic bus_write;
    logic [15:0] fb_curr_zero;
    logic [16:0] fb_curr_scaled;
    logic [15:0] feedback;
    logic signed [16:0] error_raw;
    logic signed [16:0] error_val;
    logic signed [16:0] d_in;
    logic signed [35:0] pid_sum;
    logic signed [24:0] integ_sum;
    logic [16:0] oc_limit;
    logic oc_trip;
    logic gf_trip;
    logic sc_trip;
    logic [7:0] trip_code;
    logic reset_req;
    logic [31:0] disp_prod;
    logic [31:0] read_word;
    logic read_hit;

    assign tick = (state_reg.tick_cnt == TICK_LAST);
    assign bus_setup = psel && !penable;
    assign bus_write = psel && penable && pwrite && state_reg.pready;

    // Current loop input removes the 4 mA live zero and rescales to full span.
    assign fb_curr_zero = (feedback_curr > FB_LIVE_ZERO) ? (feedback_curr - FB_LIVE_ZERO) : 16'h0000;
    assign fb_curr_scaled = {1'b0, fb_curr_zero} + {3'b000, fb_curr_zero[15:2]};

    always_comb begin
        unique case (state_reg.fb_sel)
            FB_SEL_CURR: feedback = fb_curr_scaled[16] ? 16'hFFFF : fb_curr_scaled[15:0];
            FB_SEL_VOLT: feedback = feedback_volt;
            default: feedback = 16'h0000;
        endcase
    end

    assign error_raw = signed'({1'b0, state_reg.setpoint}) - signed'({1'b0, feedback});
    assign error_val = state_reg.mode[1] ? -error_raw : error_raw;
    assign d_in = state_reg.mode[2] ? signed'({1'b0, feedback}) : error_val;
    assign integ_sum = 25'(state_reg.integ) + 25'(error_val);

    always_comb begin
        pid_sum = pprf_mul_q8(18'(error_val), state_reg.kp);
        pid_sum = pid_sum + 36'(state_reg.integ);
        pid_sum = pid_sum + pprf_mul_q8(18'(d_in) - 18'(state_reg.d_prev), state_reg.kd);
        if (state_reg.mode[3]) begin
            pid_sum = pid_sum + 36'(signed'({1'b0, state_reg.setpoint}));
        end
    end

    // Overcurrent above twice rated, ground leak above half rated.
    assign oc_limit = {state_reg.rated, 1'b0};
    assign oc_trip = {1'b0, out_current} > oc_limit;
    assign gf_trip = state_reg.ground_en && ({ground_current, 1'b0} > {1'b0, state_reg.rated});
    assign sc_trip = state_reg.ground_en && short_detect;
    assign trip_code = sc_trip ? CODE_SHORT : gf_trip ? CODE_GROUND : oc_trip ? CODE_OVERCURRENT : CODE_NONE;

    assign reset_req = (keypad_reset || (digital_in && state_reg.di_func == DI_FAULT_RESET) ||
                        (bus_write && paddr == OFS_FAULT_CLR && pwdata[0]));

    assign disp_prod = 32'(state_reg.setpoint) * 32'(state_reg.disp_range);

    ////////////////////////////////////////////////////////////////////////////
    // Register read decode.

    always_comb begin
        read_word = 32'h00000000;
        read_hit = 1'b1;
        unique case (paddr)
            OFS_MODE: read_word = {28'h0000000, state_reg.mode};
            OFS_FB_SEL: read_word = {24'h000000, state_reg.fb_sel};
            OFS_SLEEP_SEL: read_word = {24'h000000, state_reg.sleep_sel};
            OFS_SETPOINT: read_word = {16'h0000, state_reg.setpoint};
            OFS_KP: read_word = {16'h0000, state_reg.kp};
            OFS_TI: read_word = {16'h0000, state_reg.ti};
            OFS_KD: read_word = {16'h0000, state_reg.kd};
            OFS_SLEEP_LVL: read_word = {16'h0000, state_reg.sleep_lvl};
            OFS_SLEEP_DLY: read_word = {16'h0000, state_reg.sleep_dly};
            OFS_WAKE_LVL: read_word = {16'h0000, state_reg.wake_lvl};
            OFS_WAKE_DLY: read_word = {16'h0000, state_reg.wake_dly};
            OFS_MAIN_SRC: read_word = {24'h000000, state_reg.main_src};
            OFS_PROT: read_word = {30'h00000000, state_reg.ramp_sel, state_reg.ground_en};
            OFS_RATED: read_word = {16'h0000, state_reg.rated};
            OFS_DI_FUNC: read_word = {24'h000000, state_reg.di_func};
            OFS_DISP_RANGE: read_word = {16'h0000, state_reg.disp_range};
            OFS_DISP_UNIT: read_word = {24'h000000, state_reg.disp_unit};
            OFS_DISP_VAL: read_word = {8'h00, state_reg.disp_unit, disp_prod[31:16]};
            OFS_STATUS: read_word = {8'h00, state_reg.warn_code, state_reg.fault_code,
                                     5'h00, state_reg.asleep, state_reg.output_on, state_reg.fault_contact};
            OFS_FAULT_CLR: read_word = 32'h00000000;
            OFS_PID_OUT: read_word = {state_reg.freq_ref, state_reg.pid_out};
            OFS_HISTORY: read_word = state_reg.history;
            default: read_hit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        state_next = state_reg;

        // Zero-wait slave: answer lands in the first access cycle.
        state_next.pready = bus_setup;
        state_next.pslverr = bus_setup && !read_hit;
        state_next.prdata = (bus_setup && !pwrite) ? read_word : 32'h00000000;
        if (bus_write) begin
            unique case (paddr)
                OFS_MODE: state_next.mode = pwdata[3:0];
                OFS_FB_SEL: state_next.fb_sel = pwdata[7:0];
                OFS_SLEEP_SEL: state_next.sleep_sel = pwdata[7:0];
                OFS_SETPOINT: state_next.setpoint = pwdata[15:0];
                OFS_KP: state_next.kp = pwdata[15:0];
                OFS_TI: state_next.ti = pwdata[15:0];
                OFS_KD: state_next.kd = pwdata[15:0];
                OFS_SLEEP_LVL: state_next.sleep_lvl = pwdata[15:0];
                OFS_SLEEP_DLY: state_next.sleep_dly = pwdata[15:0];
                OFS_WAKE_LVL: state_next.wake_lvl = pwdata[15:0];
                OFS_WAKE_DLY: state_next.wake_dly = pwdata[15:0];
                OFS_MAIN_SRC: state_next.main_src = pwdata[7:0];
                OFS_PROT: {state_next.ramp_sel, state_next.ground_en} = pwdata[1:0];
                OFS_RATED: state_next.rated = pwdata[15:0];
                OFS_DI_FUNC: state_next.di_func = pwdata[7:0];
                OFS_DISP_RANGE: state_next.disp_range = pwdata[15:0];
                OFS_DISP_UNIT: state_next.disp_unit = pwdata[7:0];
                default: state_next.pslverr = 1'b0;
            endcase
        end

        state_next.tick_cnt = tick ? 6'h00 : state_reg.tick_cnt + 6'h01;

        // Regulator runs on each control update.
        if (!state_reg.mode[0]) begin
            state_next.integ = 24'sh000000;
            state_next.ti_cnt = 16'h0000;
            state_next.d_prev = 17'sh00000;
            if (tick) begin
                state_next.pid_out = 16'h0000;
            end
        end else if (tick) begin
            state_next.pid_out = pprf_clamp16(pid_sum);
            state_next.d_prev = d_in;
            if (state_reg.ti_cnt >= state_reg.ti) begin
                state_next.ti_cnt = 16'h0000;
                if (integ_sum > 25'(INTEG_MAX)) begin
                    state_next.integ = INTEG_MAX;
                end else if (integ_sum < 25'(INTEG_MIN)) begin
                    state_next.integ = INTEG_MIN;
                end else begin
                    state_next.integ = integ_sum[23:0];
                end
            end else begin
                state_next.ti_cnt = state_reg.ti_cnt + 16'h0001;
            end
        end

        state_next.freq_ref = (state_reg.main_src == MAIN_SRC_PID) ? state_reg.pid_out : other_ref;

        // Sleep supervisor.
        unique case (state_reg.sleep_sel)
            SLEEP_LEVEL: begin
                if (tick) begin
                    if (!state_reg.asleep) begin
                        if (state_reg.pid_out < state_reg.sleep_lvl) begin
                            state_next.delay_cnt = state_reg.delay_cnt + 16'h0001;
                            if (state_reg.delay_cnt >= state_reg.sleep_dly) begin
                                state_next.asleep = 1'b1;
                                state_next.delay_cnt = 16'h0000;
                            end
                        end else begin
                            state_next.delay_cnt = 16'h0000;
                        end
                    end else begin
                        if (state_reg.pid_out > state_reg.wake_lvl) begin
                            state_next.delay_cnt = state_reg.delay_cnt + 16'h0001;
                            if (state_reg.delay_cnt >= state_reg.wake_dly) begin
                                state_next.asleep = 1'b0;
                                state_next.delay_cnt = 16'h0000;
                            end
                        end else begin
                            state_next.delay_cnt = 16'h0000;
                        end
                    end
                end
            end
            SLEEP_INPUT: begin
                state_next.asleep = sleep_input;
                state_next.delay_cnt = 16'h0000;
            end
            default: begin
                state_next.asleep = 1'b0;
                state_next.delay_cnt = 16'h0000;
            end
        endcase

        // Fault latch: a new trip wins over a reset in the same cycle.
        if (trip_code != CODE_NONE && !state_reg.fault_contact) begin
            state_next.fault_code = trip_code;
            state_next.fault_contact = 1'b1;
            state_next.coast_stop = !(state_reg.ramp_sel && trip_code == CODE_GROUND);
            state_next.ramp_stop = state_reg.ramp_sel && trip_code == CODE_GROUND;
            state_next.history = {state_reg.history[23:0], trip_code};
        end else if (reset_req && trip_code == CODE_NONE) begin
            state_next.fault_code = CODE_NONE;
            state_next.fault_contact = 1'b0;
            state_next.coast_stop = 1'b0;
            state_next.ramp_stop = 1'b0;
        end

        // Warnings follow their source and never touch the contact.
        state_next.warn_code = warning_in;
        state_next.output_on = !state_next.asleep && !state_next.fault_contact;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
            state_reg.mode <= MODE_RESET;
            state_reg.fb_sel <= FB_SEL_RESET;
            state_reg.kp <= KP_RESET;
            state_reg.ti <= TI_RESET;
            state_reg.rated <= WORD_RESET;
            state_reg.sleep_sel <= BYTE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign prdata = state_reg.prdata;
    assign pready = state_reg.pready;
    assign pslverr = state_reg.pslverr;
    assign freq_ref = state_reg.freq_ref;
    assign output_on = state_reg.output_on;
    assign fault_contact = state_reg.fault_contact;
    assign fault_code = state_reg.fault_code;
    assign warning_code = state_reg.warn_code;
    assign coast_stop = state_reg.coast_stop;
    assign ramp_stop = state_reg.ramp_stop;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_trip_idle;
        (trip_code != CODE_NONE) && !state_reg.fault_contact;
    endsequence

    sequence seq_latched;
        state_reg.fault_contact && (state_reg.fault_code != CODE_NONE);
    endsequence

    chk_off_zero_out: assert property (!state_reg.mode[0] && tick |=> state_reg.pid_out == 16'h0000)
        else $error("Regulator output not zero while disabled.");
    chk_integ_hold: assert property (!state_reg.mode[0] |=> state_reg.integ == 24'sh000000)
        else $error("Integral not held at zero while disabled.");
    chk_src_select: assert property (state_reg.main_src == MAIN_SRC_PID |=> freq_ref == $past(state_reg.pid_out))
        else $error("Reference does not follow regulator output.");
    chk_fault_latch: assert property (seq_trip_idle |=> seq_latched ##1 fault_contact)
        else $error("Trip did not latch the fault contact.");
    chk_overcurrent_trip: assert property (oc_trip && !state_reg.fault_contact && !sc_trip && !gf_trip
                                           |=> fault_code == CODE_OVERCURRENT)
        else $error("Overcurrent did not give its code.");
    chk_history_record: assert property (seq_trip_idle |=> state_reg.history[7:0] == state_reg.fault_code)
        else $error("Fault not recorded in history.");
    chk_fault_reset: assert property (state_reg.fault_contact && reset_req && trip_code == CODE_NONE
                                      |=> !fault_contact [*2])
        else $error("Fault reset request ignored.");
    chk_warn_contact: assert property (!state_reg.fault_contact && trip_code == CODE_NONE && warning_in != 8'h00
                                       |=> warning_code == $past(warning_in) && !fault_contact)
        else $error("Warning energised the fault contact.");
    chk_sleep_off: assert property ($rose(state_reg.asleep) |=> !output_on)
        else $error("Output still on after entering sleep.");
    chk_apb_answer: assert property (bus_setup |=> pready ##1 !pready || $past(bus_setup, 1))
        else $error("Slave answer not one cycle after setup.");
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench for the process regulator and fault handling.
// Assumes: One access cycle per APB transfer, control updates every 50 cycles.
// Notes: Expected values come from the register map and trip thresholds.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin errors++; $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb_top;
    import pprf_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 0, fault_code, warning_code, warning_in = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [15:0] fv, fc, oc, gc, freq_ref, other_ref = 16'h1234, fb_set = 0, load = 0, leak = 0;
    logic sd, short_cmd = 0, digital_in = 0, keypad_reset = 0, sleep_in = 0, perr;
    logic output_on, fault_contact, coast_stop, ramp_stop;
    int errors = 0, checks = 0;
    pprf_plant pprf_plant_i (.pclk(pclk), .presetn(presetn), .fb_set(fb_set), .load(load), .leak(leak),
        .short_cmd(short_cmd), .feedback_volt(fv), .feedback_curr(fc), .out_current(oc),
        .ground_current(gc), .short_detect(sd));
    pprf_top pprf_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .feedback_volt(fv), .feedback_curr(fc), .other_ref(other_ref), .out_current(oc),
        .ground_current(gc), .short_detect(sd), .sleep_input(sleep_in), .digital_in(digital_in),
        .keypad_reset(keypad_reset), .warning_in(warning_in), .freq_ref(freq_ref),
        .output_on(output_on), .fault_contact(fault_contact), .fault_code(fault_code),
        .warning_code(warning_code), .coast_stop(coast_stop), .ramp_stop(ramp_stop));
    initial forever #10 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic t_reset_values;
        apb(0, OFS_MODE, 0); `CHK(rd, 32'h0)
        apb(0, OFS_FB_SEL, 0); `CHK(rd, 32'h1)
        apb(0, OFS_KP, 0); `CHK(rd, 32'h200)
        apb(0, OFS_TI, 0); `CHK(rd, 32'h5)
        apb(0, 8'hFC, 0); `CHK(perr, 1'b1)
        $display("test reset_values done");
    endtask
    task automatic t_regulator;
        wr(OFS_MAIN_SRC, 0); wr(OFS_SETPOINT, 32'h1000); fb_set <= 16'h0800;
        repeat (5) @(posedge pclk);
        `CHK(freq_ref, other_ref)
        wr(OFS_MAIN_SRC, 5); wr(OFS_MODE, 1);
        repeat (300) @(posedge pclk);
        apb(0, OFS_PID_OUT, 0);
        `CHK(rd[15:0] > 16'h0FFF, 1'b1)
        `CHK(freq_ref, rd[15:0])
        wr(OFS_MODE, 0); wr(OFS_MODE, 3);
        repeat (300) @(posedge pclk);
        apb(0, OFS_PID_OUT, 0); `CHK(rd[15:0], 16'h0)
        $display("test regulator done");
    endtask
    task automatic t_faults;
        wr(OFS_RATED, 32'h100); load <= 16'h0200; warning_in <= 8'h05;
        repeat (5) @(posedge pclk);
        `CHK(fault_contact, 1'b0)
        `CHK(warning_code, 8'h05)
        load <= 16'h0201; warning_in <= 0;
        repeat (5) @(posedge pclk);
        `CHK({fault_contact, coast_stop, output_on, fault_code}, {3'b110, CODE_OVERCURRENT})
        apb(0, OFS_HISTORY, 0); `CHK(rd[7:0], CODE_OVERCURRENT)
        load <= 0; keypad_reset <= 1;
        repeat (3) @(posedge pclk);
        keypad_reset <= 0;
        repeat (3) @(posedge pclk);
        `CHK(fault_contact, 1'b0)
        wr(OFS_PROT, 1); wr(OFS_DI_FUNC, 32'h11); leak <= 16'h0081;
        repeat (5) @(posedge pclk);
        `CHK(fault_code, CODE_GROUND)
        leak <= 0; digital_in <= 1;
        repeat (3) @(posedge pclk);
        digital_in <= 0; short_cmd <= 1;
        repeat (5) @(posedge pclk);
        `CHK(fault_code, CODE_SHORT)
        apb(0, OFS_STATUS, 0); `CHK(rd[0], 1'b1)
        short_cmd <= 0; keypad_reset <= 1;
        repeat (3) @(posedge pclk);
        keypad_reset <= 0;
        $display("test faults done");
    endtask
    task automatic t_sleep;
        wr(OFS_MODE, 1); wr(OFS_SETPOINT, 0); fb_set <= 0;
        wr(OFS_SLEEP_LVL, 32'h10); wr(OFS_SLEEP_DLY, 3); wr(OFS_SLEEP_SEL, 1);
        repeat (60) @(posedge pclk);
        `CHK(output_on, 1'b1)
        repeat (400) @(posedge pclk);
        `CHK(output_on, 1'b0)
        wr(OFS_WAKE_LVL, 32'h10); wr(OFS_WAKE_DLY, 3); wr(OFS_SETPOINT, 32'h4000);
        repeat (500) @(posedge pclk);
        `CHK(output_on, 1'b1)
        $display("test sleep done");
    endtask
    task automatic t_modes;
        fb_set <= 16'h0400; wr(OFS_MODE, 8); wr(OFS_FB_SEL, 2); wr(OFS_SETPOINT, 32'h500); wr(OFS_MODE, 9);
        wr(OFS_DISP_RANGE, 32'h8000); wr(OFS_DISP_UNIT, 2);
        repeat (120) @(posedge pclk);
        apb(0, OFS_PID_OUT, 0); `CHK(rd[15:0], 16'h0500)
        apb(0, OFS_DISP_VAL, 0); `CHK(rd, 32'h00020280)
        wr(OFS_SLEEP_SEL, 2); sleep_in <= 1;
        repeat (3) @(posedge pclk);
        `CHK(output_on, 1'b0)
        sleep_in <= 0;
        repeat (3) @(posedge pclk);
        `CHK(output_on, 1'b1)
        wr(OFS_PROT, 3); leak <= 16'h0081;
        repeat (5) @(posedge pclk);
        `CHK({ramp_stop, coast_stop, fault_code}, {2'b10, CODE_GROUND})
        leak <= 0;
        repeat (3) @(posedge pclk);
        wr(OFS_FAULT_CLR, 1);
        @(posedge pclk);
        `CHK(fault_contact, 1'b0)
        $display("test modes done");
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_reset_values;
        t_regulator;
        t_faults;
        t_sleep;
        t_modes;
        complete_run;
    end
    initial begin
        #400000;
        errors++;
        complete_run;
    end
endmodule
